// ### rtl/fbp_pkg.sv
// constants for the four-bit port with upper address sharing
package fbp_pkg;
	localparam logic [19:0] PORT_DIRECTION_ADDR    = 20'hEE004;
	localparam logic [19:0] PULLUP_CONTROL_ADDR    = 20'hEE03F;
	localparam logic [19:0] PORT_OUTPUT_DATA_ADDR  = 20'hFFFD4;
	localparam int          PIN_COUNT              = 4;
	localparam logic [7:0]  RESERVED_HIGH          = 8'hF0;
	localparam logic [3:0]  DIR_RESET_ADDR_MODE    = 4'hF;
	localparam logic [3:0]  DIR_RESET_OTHER_MODE   = 4'h0;
	localparam logic [3:0]  DATA_RESET             = 4'h0;
	localparam logic [3:0]  PULLUP_RESET           = 4'h0;
	localparam logic [7:0]  UNMAPPED_READ          = 8'h00;
	localparam logic [2:0]  MODE_ADDR_LAST         = 3'h4;
	localparam logic [2:0]  MODE_MIXED             = 3'h5;
	localparam logic [2:0]  MODE_SINGLE_FIRST      = 3'h6;
	typedef enum logic [3:0]
	{
		PIN_ADDRESS = 4'h1,
		PIN_INPUT   = 4'h2,
		PIN_OUTPUT  = 4'h4,
		PIN_HIZ_OFF = 4'h8
	} fbp_pin_role_type;
endpackage

// ### rtl/fbp_pin_cell.sv
// one port pin: role selection, output drive and pull-up gating
`timescale 1ns/100ps
`default_nettype none
module fbp_pin_cell
(
	input  wire logic [2:0] mode,           // operating mode 1..7
	input  wire logic       hold,           // reset or hardware standby
	input  wire logic       dir_bit,        // direction bit
	input  wire logic       data_bit,       // latched data bit
	input  wire logic       pullup_bit,     // pull-up control bit
	input  wire logic       addr_bit,       // bus controller address bit
	output logic            pin_out,        // pin output level
	output logic            pin_oe,         // pin drive enable
	output logic            pullup_en       // pull-up transistor on
);
	fbp_pkg::fbp_pin_role_type role;

	always_comb
	begin
		if (hold)
			role = fbp_pkg::PIN_HIZ_OFF;
		else if (mode <= fbp_pkg::MODE_ADDR_LAST)
			role = fbp_pkg::PIN_ADDRESS;
		else if (mode == fbp_pkg::MODE_MIXED)
			role = dir_bit ? fbp_pkg::PIN_ADDRESS : fbp_pkg::PIN_INPUT;
		else
			role = dir_bit ? fbp_pkg::PIN_OUTPUT : fbp_pkg::PIN_INPUT;
	end

	always_comb
	begin
		pin_out   = 1'b0;
		pin_oe    = 1'b0;
		pullup_en = 1'b0;
		unique case (role)
			fbp_pkg::PIN_ADDRESS:
			begin
				pin_out = addr_bit;
				pin_oe  = 1'b1;
			end
			fbp_pkg::PIN_OUTPUT:
			begin
				pin_out = data_bit;
				pin_oe  = 1'b1;
			end
			fbp_pkg::PIN_INPUT:
				pullup_en = pullup_bit;
			fbp_pkg::PIN_HIZ_OFF:
				pullup_en = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ### rtl/fbp_read_mux.sv
// read-back selection for the three port registers
`timescale 1ns/100ps
`default_nettype none
module fbp_read_mux
(
	input  wire logic [19:0] addr,          // register address
	input  wire logic [3:0]  dir,           // direction bits
	input  wire logic [3:0]  data,          // latched data bits
	input  wire logic [3:0]  pullup_ctl,    // pull-up control bits
	input  wire logic [3:0]  pin_level,     // live pin levels
	output logic      [7:0]  rdata          // read value
);
	always_comb
	begin
		unique case (addr)
			fbp_pkg::PORT_DIRECTION_ADDR:
				rdata = 8'hFF;
			fbp_pkg::PORT_OUTPUT_DATA_ADDR:
				rdata = fbp_pkg::RESERVED_HIGH | {4'h0, (dir & data) | (~dir & pin_level)};
			fbp_pkg::PULLUP_CONTROL_ADDR:
				rdata = fbp_pkg::RESERVED_HIGH | {4'h0, pullup_ctl};
			default:
				rdata = fbp_pkg::UNMAPPED_READ;
		endcase
	end
endmodule
`default_nettype wire

// ### rtl/fbp_port.sv
// four-bit port shared with the upper address outputs
//
// Added by the designer: the port shared with the upper address outputs.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - modes 1 to 4: all pins drive upper address outputs
// - mode 5: direction 1 gives address output, 0 gives input
// - mode 5: all pins inputs after reset until software sets direction
// - modes 6 and 7: direction 1 output, 0 input
// - modes 1 to 4: direction reads all ones, writes ignored
// - modes 5 to 7: direction writable, reads all ones
// - direction resets to FF in modes 1-4, F0 in modes 5-7
// - software standby keeps all three registers
// - generic outputs keep driving through software standby
// - upper four bits of each register read one, ignore writes
// - generic output pin drives its data bit
// - data read gives latch if direction 1, pin if 0
// - data register resets to F0
// - modes 5-7: pull-up on only if control 1, direction 0
// - pull-up control resets to F0
// - pull-ups off in reset, hardware standby, and modes 1-4
module fbp_port
#(
	parameter int PINS = fbp_pkg::PIN_COUNT
)
(
	input  wire logic            mclk,            // 125 MHz clock
	input  wire logic            rst,             // async reset, high
	input  wire logic            clk_en,          // freezes all state when low
	input  wire logic [2:0]      mode,            // operating mode 1..7
	input  wire logic            hw_standby,      // hardware standby, high
	input  wire logic            sw_standby,      // software standby, high
	input  wire logic [19:0]     reg_addr,        // register address
	input  wire logic [7:0]      reg_wdata,       // write data
	input  wire logic            reg_wr,          // write strobe
	input  wire logic            reg_rd,          // read strobe
	output logic      [7:0]      reg_rdata,       // read data, cycle after strobe
	input  wire logic [PINS-1:0] upper_address_outputs, // bus controller upper address
	input  wire logic [PINS-1:0] pin_in,          // pin levels
	output logic      [PINS-1:0] pin_out,         // pin drive levels
	output logic      [PINS-1:0] pin_oe,          // pin drive enables
	output logic      [PINS-1:0] pullup_en        // pull-up enables
);
	typedef enum logic [3:0]
	{
		SEL_NONE      = 4'h1,
		SEL_DIRECTION = 4'h2,
		SEL_DATA      = 4'h4,
		SEL_PULLUP    = 4'h8
	} fbp_reg_sel_type;

	// register state and the strobe decode
	logic [3:0]      port_direction_q;
	logic [3:0]      port_direction_d;
	logic [3:0]      port_output_data_q;
	logic [3:0]      port_output_data_d;
	logic [3:0]      pullup_control_q;
	logic [3:0]      pullup_control_d;
	logic            init_q;
	logic [7:0]      rdata_q;
	logic [7:0]      rdata_d;
	logic [7:0]      rd_value;
	logic            addr_mode;
	logic            hold;
	logic            hold_pins;
	logic            wr_ok;
	fbp_reg_sel_type wr_sel;
	logic [3:0]      wr_nibble;
	logic [3:0]      dir_reset;

	// modes 1 to 4 hand every pin to the bus controller
	function automatic logic addr_only
	(
		logic [2:0] m
	);
		addr_only = (m <= fbp_pkg::MODE_ADDR_LAST);
	endfunction

	// unmapped addresses give no select, so such writes are dropped
	function automatic fbp_reg_sel_type decode_sel
	(
		logic [19:0] addr
	);
		unique case (addr)
			fbp_pkg::PORT_DIRECTION_ADDR:
				decode_sel = SEL_DIRECTION;
			fbp_pkg::PORT_OUTPUT_DATA_ADDR:
				decode_sel = SEL_DATA;
			fbp_pkg::PULLUP_CONTROL_ADDR:
				decode_sel = SEL_PULLUP;
			default:
				decode_sel = SEL_NONE;
		endcase
	endfunction

	function automatic logic [3:0] direction_reset
	(
		logic [2:0] m
	);
		if (addr_only(m))
			direction_reset = fbp_pkg::DIR_RESET_ADDR_MODE;
		else
			direction_reset = fbp_pkg::DIR_RESET_OTHER_MODE;
	endfunction

	// the reserved high nibble never takes write data
	function automatic logic [3:0] low_nibble
	(
		logic [7:0] value
	);
		low_nibble = value[3:0];
	endfunction

	assign addr_mode = addr_only(mode);
	assign dir_reset = direction_reset(mode);
	assign wr_nibble = low_nibble(reg_wdata);
	// hardware standby reinitialises like a reset; software standby does not
	assign hold      = hw_standby | init_q;
	// pull-ups and drivers off in reset
	assign hold_pins = hold | rst;

	// writes refused in software standby so contents survive it
	always_comb
	begin
		wr_ok  = reg_wr & ~sw_standby & ~hold;
		wr_sel = SEL_NONE;
		if (wr_ok)
		begin
			wr_sel = decode_sel(reg_addr);
		end
	end

	// the mode pins are only valid after release, so the mode-dependent
	// values are loaded one enabled edge later through init_q
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			init_q <= 1'b1;
		end
		else if (clk_en)
		begin
			init_q <= 1'b0;
		end
	end

	always_comb
	begin
		port_direction_d = port_direction_q;
		if (hold)
		begin
			port_direction_d = dir_reset;
		end
		else
		begin
			unique case (wr_sel)
				SEL_DIRECTION:
					if (!addr_mode)
						port_direction_d = wr_nibble;
				SEL_DATA,
				SEL_PULLUP,
				SEL_NONE:
					port_direction_d = port_direction_q;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		// every pin an input until the init edge
		if (rst)
		begin
			port_direction_q <= fbp_pkg::DIR_RESET_OTHER_MODE;
		end
		else if (clk_en)
		begin
			port_direction_q <= port_direction_d;
		end
	end

	always_comb
	begin
		port_output_data_d = port_output_data_q;
		if (hold)
		begin
			port_output_data_d = fbp_pkg::DATA_RESET;
		end
		else
		begin
			unique case (wr_sel)
				SEL_DATA:
					port_output_data_d = wr_nibble;
				SEL_DIRECTION,
				SEL_PULLUP,
				SEL_NONE:
					port_output_data_d = port_output_data_q;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			port_output_data_q <= fbp_pkg::DATA_RESET;
		end
		else if (clk_en)
		begin
			port_output_data_q <= port_output_data_d;
		end
	end

	always_comb
	begin
		pullup_control_d = pullup_control_q;
		if (hold)
		begin
			pullup_control_d = fbp_pkg::PULLUP_RESET;
		end
		else
		begin
			unique case (wr_sel)
				SEL_PULLUP:
					pullup_control_d = wr_nibble;
				SEL_DIRECTION,
				SEL_DATA,
				SEL_NONE:
					pullup_control_d = pullup_control_q;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pullup_control_q <= fbp_pkg::PULLUP_RESET;
		end
		else if (clk_en)
		begin
			pullup_control_q <= pullup_control_d;
		end
	end

	// read data stand for one cycle and are zero otherwise
	always_comb
	begin
		rdata_d = 8'h00;
		if (reg_rd)
		begin
			rdata_d = rd_value;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rdata_q <= 8'h00;
		end
		else if (clk_en)
		begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// the mux sees the live pins so input bits read their level
	fbp_read_mux u_read_mux
	(
		.addr       (reg_addr),
		.dir        (port_direction_q),
		.data       (port_output_data_q),
		.pullup_ctl (pullup_control_q),
		.pin_level  (pin_in[3:0]),
		.rdata      (rd_value)
	);

	// one cell per pin keeps the role logic identical across pins
	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++)
		begin : g_pin
			fbp_pin_cell u_cell
			(
				.mode       (mode),
				.hold       (hold_pins),
				.dir_bit    (port_direction_q[gi]),
				.data_bit   (port_output_data_q[gi]),
				.pullup_bit (pullup_control_q[gi]),
				.addr_bit   (upper_address_outputs[gi]),
				.pin_out    (pin_out[gi]),
				.pin_oe     (pin_oe[gi]),
				.pullup_en  (pullup_en[gi])
			);
		end
	endgenerate
endmodule
`default_nettype wire

// ### testbench/fbp_pin_model.sv
// far side of the port pins: outside drivers and floating lines
`timescale 1ns/100ps
`default_nettype none
module fbp_pin_model
(
	input  wire logic       mclk,      // clock
	input  wire logic [3:0] pin_out,   // device drive level
	input  wire logic [3:0] pin_oe,    // device drive enable
	input  wire logic [3:0] pullup_en, // device pull-up
	input  wire logic [3:0] ext_drive, // outside driver on
	input  wire logic [3:0] ext_level, // outside level
	output logic      [3:0] level      // resolved pin level
);
	logic [3:0] float_q = 4'h5;
	// a floating pin wanders so it never reads as a tidy constant
	always_ff @(posedge mclk)
		float_q <= ~level;
	always_comb
		level = pin_oe & pin_out | ~pin_oe & (ext_drive & ext_level | ~ext_drive & (pullup_en | float_q));
endmodule
`default_nettype wire

// ### testbench/fbp_port_sva.sv
// checker for the four-bit port
`timescale 1ns/100ps
`default_nettype none
module fbp_port_sva
#(
	parameter int PINS = 4
)
(
	input  wire logic            mclk,                  // clock
	input  wire logic            rst,                   // async reset
	input  wire logic            clk_en,                // clock enable
	input  wire logic            hw_standby,            // hardware standby
	input  wire logic            sw_standby,            // software standby
	input  wire logic            reg_wr,                // write strobe
	input  wire logic            reg_rd,                // read strobe
	input  wire logic [2:0]      mode,                  // operating mode
	input  wire logic [19:0]     reg_addr,              // register address
	input  wire logic [7:0]      reg_wdata,             // write data
	input  wire logic [7:0]      reg_rdata,             // read data
	input  wire logic [PINS-1:0] upper_address_outputs, // address bits
	input  wire logic [PINS-1:0] pin_in,                // pin levels
	input  wire logic [PINS-1:0] pin_out,               // drive levels
	input  wire logic [PINS-1:0] pin_oe,                // drive enables
	input  wire logic [PINS-1:0] pullup_en              // pull-up enables
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_addr;
		mode <= 3'h4 && !hw_standby && !$past(rst) && !$past(hw_standby)
		|-> pin_oe == '1 && pin_out == upper_address_outputs;
	endproperty
	a_addr: assert property (p_addr) else $error("address pins wrong");
	property p_pull_off;
		mode <= 3'h4 || hw_standby |-> pullup_en == '0;
	endproperty
	a_pull_off: assert property (p_pull_off) else $error("pull-up not off");
	property p_dir_rd;
		clk_en && reg_rd && reg_addr == 20'hEE004 |=> reg_rdata == 8'hFF;
	endproperty
	a_dir_rd: assert property (p_dir_rd) else $error("direction read not FF");
	property p_data_rd;
		clk_en && reg_rd && reg_addr == 20'hFFFD4 && mode >= 3'h6 && !hw_standby |=> reg_rdata ==
		{4'hF, $past(pin_oe) & $past(pin_out) | ~$past(pin_oe) & $past(pin_in)};
	endproperty
	a_data_rd: assert property (p_data_rd) else $error("data read wrong");
	property p_pull_in;
		mode >= 3'h5 |-> (pullup_en & pin_oe) == '0;
	endproperty
	a_pull_in: assert property (p_pull_in) else $error("pull-up on output");
	property p_mix;
		mode == 3'h5 |-> (pin_out & pin_oe) == (upper_address_outputs & pin_oe);
	endproperty
	a_mix: assert property (p_mix) else $error("mixed pin not address");
	property p_boot;
		$fell(rst) && mode == 3'h5 |-> (pin_oe == '0) [*2];
	endproperty
	a_boot: assert property (p_boot) else $error("pins driven after reset");
	property p_hold;
		mode >= 3'h6 && sw_standby && !hw_standby ##1 sw_standby && !hw_standby
		|-> $stable(pin_oe) && $stable(pin_out);
	endproperty
	a_hold: assert property (p_hold) else $error("pins moved in standby");
	c_rd: cover property (reg_rd && reg_addr == 20'hFFFD4);
	c_sw: cover property (sw_standby && pin_oe != '0);
	c_mix: cover property (mode == 3'h5 && pin_oe != '0);
endmodule
bind fbp_port fbp_port_sva #(.PINS(PINS)) u_sva
(
	.mclk                  (mclk),
	.rst                   (rst),
	.clk_en                (clk_en),
	.hw_standby            (hw_standby),
	.sw_standby            (sw_standby),
	.reg_wr                (reg_wr),
	.reg_rd                (reg_rd),
	.mode                  (mode),
	.reg_addr              (reg_addr),
	.reg_wdata             (reg_wdata),
	.reg_rdata             (reg_rdata),
	.upper_address_outputs (upper_address_outputs),
	.pin_in                (pin_in),
	.pin_out               (pin_out),
	.pin_oe                (pin_oe),
	.pullup_en             (pullup_en)
);
`default_nettype wire

// ### testbench/fbp_port_tb_top.sv
// self-checking bench for the four-bit port
`timescale 1ns/100ps
`default_nettype none
module fbp_port_tb_top;
	localparam logic [19:0] DIR = fbp_pkg::PORT_DIRECTION_ADDR;
	localparam logic [19:0] DAT = fbp_pkg::PORT_OUTPUT_DATA_ADDR;
	localparam logic [19:0] PUC = fbp_pkg::PULLUP_CONTROL_ADDR;
	typedef struct {logic w; logic [19:0] a; logic [7:0] d;} fbp_row_type;
	logic mclk = 0, rst = 1, wr = 0, rd = 0, sws = 0, hws = 0, ce = 1;
	logic [2:0] mode = 3'h7;
	logic [19:0] addr = '0;
	logic [7:0] wd = '0, rdata;
	logic [3:0] ua = 4'h9, lvl, po, oe, pu, ed = 4'hF, el = 4'h2;
	int bad_count = 0, check_count = 0, cyc = 0;
	fbp_row_type rows [10] = '{'{0, DIR, 8'hFF}, '{0, DAT, 8'hF2}, '{0, PUC, 8'hF0}, '{1, PUC, 8'h31},
		'{0, PUC, 8'hF1}, '{1, DAT, 8'h38}, '{1, DIR, 8'h0C}, '{0, DIR, 8'hFF}, '{0, DAT, 8'hFA}, '{0, 20'h0, 8'h00}};
	always #4 mclk = ~mclk;
	fbp_port dut (.mclk(mclk), .rst(rst), .clk_en(ce), .mode(mode), .hw_standby(hws), .sw_standby(sws),
		.reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .upper_address_outputs(ua),
		.pin_in(lvl), .pin_out(po), .pin_oe(oe), .pullup_en(pu));
	fbp_pin_model far (.mclk(mclk), .pin_out(po), .pin_oe(oe), .pullup_en(pu), .ext_drive(ed), .ext_level(el),
		.level(lvl));
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp4(string n, logic [3:0] e, logic [3:0] g);
		cmp8(n, {4'h0, e}, {4'h0, g});
	endtask
	task automatic wreg(logic [19:0] a, logic [7:0] d);
		@(posedge mclk);
		{wr, addr, wd} <= {1'b1, a, d};
		@(posedge mclk);
		wr <= 0;
		#1;
	endtask
	task automatic rchk(logic [19:0] a, logic [7:0] e);
		@(posedge mclk);
		{rd, addr} <= {1'b1, a};
		@(posedge mclk);
		rd <= 0;
		#1 cmp8("read", e, rdata);
	endtask
	// mode is only changed while reset is held
	task automatic boot(logic [2:0] m);
		{rst, mode} <= {1'b1, m};
		repeat (8) @(posedge mclk);
		rst <= 0;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			bad_count++;
			finish_test();
		end
	end
	initial
	begin
		boot(3'h7);
		foreach (rows[i])
			if (rows[i].w) wreg(rows[i].a, rows[i].d); else rchk(rows[i].a, rows[i].d);
		cmp4("oe", 4'hC, oe);
		cmp4("out", 4'h8, po & oe);
		cmp4("pullup", 4'h1, pu);
		// a write while the clock enable is low must not land
		ce <= 0;
		wreg(DIR, 8'h03);
		ce <= 1;
		cmp4("oe", 4'hC, oe);
		sws <= 1;
		wreg(DAT, 8'h37);
		wreg(DIR, 8'h03);
		cmp4("oe", 4'hC, oe);
		sws <= 0;
		rchk(DAT, 8'hFA);
		hws <= 1;
		@(posedge mclk);
		#1 cmp4("pullup", 4'h0, pu | oe);
		hws <= 0;
		rchk(DAT, 8'hF2);
		rchk(PUC, 8'hF0);
		cmp4("oe", 4'h0, oe);
		wreg(DIR, 8'h0F);
		rchk(DAT, 8'hF0);
		boot(3'h5);
		cmp4("oe", 4'h0, oe);
		wreg(DIR, 8'h05);
		cmp4("out", 4'h1, po & oe);
		wreg(PUC, 8'h0A);
		cmp4("pullup", 4'hA, pu);
		boot(3'h2);
		cmp4("out", 4'h9, po & oe);
		wreg(DIR, 8'h00);
		wreg(PUC, 8'h0F);
		rchk(DIR, 8'hFF);
		cmp4("oe", 4'hF, oe & ~pu);
		finish_test();
	end
endmodule
`default_nettype wire
